// file: hw/alu_stage_pkg.sv
// shared constants, types and helpers for the alu input stage
// assumes one 100 MHz clock and a 32-bit apb register port
package alu_stage_pkg;

    // datapath geometry
    localparam int WORD_W = 16;
    localparam int SCRATCH_N = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int SHIFT_W = 4;

    // apb byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // field positions in the control word
    localparam int CTRL_PREC_POS = 0;
    localparam int CTRL_SHIFT_POS = 4;

    // field positions in the status word
    localparam int STAT_CARRY_POS = 0;
    localparam int STAT_STALL_POS = 1;
    localparam int STAT_SLICE_POS = 4;

    // multiprecision field width: one 16-bit slice per cycle
    typedef enum logic [1:0] {
        PREC_16,
        PREC_32,
        PREC_64
    } precision_e;

    // values after reset
    localparam precision_e CTRL_PREC_RESET = PREC_16;
    localparam logic [SHIFT_W-1:0] CTRL_SHIFT_RESET = 4'h0;

    // software control carried to the datapath
    typedef struct packed {
        precision_e precision;
        logic [SHIFT_W-1:0] shift_amount;
    } ctrl_s;

    // datapath state shown to software
    typedef struct packed {
        logic carry;
        logic stall;
        logic [1:0] slice;
    } status_s;

    // one word of the result stream
    typedef struct packed {
        logic last;
        logic carry;
        logic [WORD_W-1:0] data;
    } result_s;

    // index of the final slice for a field width
    function automatic logic [1:0] last_slice(input precision_e p);
        case (p)
            PREC_32: last_slice = 2'h1;
            PREC_64: last_slice = 2'h3;
            default: last_slice = 2'h0;
        endcase
    endfunction

endpackage

// file: hw/result_fifo.sv
// result fifo with a registered head word
// assumes one clock; the head register adds one word of capacity
`timescale 1ns/10ps
module result_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH]; // storage, no reset needed
    logic [PTR_W-1:0] wr_q, wr_d; // write pointer
    logic [PTR_W-1:0] rd_q, rd_d; // read pointer
    logic [PTR_W:0] count_q, count_d; // words held in storage
    logic head_valid_q, head_valid_d; // head register occupied
    logic [WIDTH-1:0] head_q, head_d; // head word shown at the port
    logic push; // word accepted this cycle
    logic pop; // word moved from storage to head

    // full is honest: ready falls as soon as storage holds depth words
    assign in_ready = (count_q != (PTR_W+1)'(DEPTH));
    assign push = in_valid & in_ready;
    assign out_valid = head_valid_q;
    assign out_data = head_q;

    // pointer, count and head next values
    always_comb begin
        pop = (count_q != '0) & (~head_valid_q | out_ready);
        wr_d = push ? PTR_W'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? PTR_W'(rd_q + 1'b1) : rd_q;
        count_d = (PTR_W+1)'(count_q + push - pop);
        head_d = pop ? mem_q[rd_q] : head_q;
        if (pop) begin
            head_valid_d = 1'b1;
        end else if (out_ready) begin
            head_valid_d = 1'b0;
        end else begin
            head_valid_d = head_valid_q;
        end
    end

    // control registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
            head_valid_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            count_q <= count_d;
            head_valid_q <= head_valid_d;
        end
    end

    // data registers carry no reset; valid flags guard them
    always_ff @(posedge clk) begin
        head_q <= head_d;
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// file: hw/stage_regs.sv
// apb slave holding the control word and reading back status
// assumes apb3 signalling; answers with one wait state
`timescale 1ns/10ps
module stage_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // datapath side
    output alu_stage_pkg::ctrl_s ctrl,
    input wire alu_stage_pkg::status_s status
);
    alu_stage_pkg::ctrl_s ctrl_q, ctrl_d; // control word
    logic [31:0] rdata_q, rdata_d; // read answer
    logic ready_q, ready_d; // access phase complete
    logic err_q, err_d; // unmapped address
    logic mapped; // address decodes to a register
    logic commit; // edge at which the master sees pready

    assign ctrl = ctrl_q;
    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;

    // next values; pready rises one cycle into the access phase
    always_comb begin
        mapped = (paddr == alu_stage_pkg::CTRL_OFFSET) |
                 (paddr == alu_stage_pkg::STATUS_OFFSET);
        commit = psel & penable & ready_q;
        ready_d = psel & penable & ~ready_q;
        err_d = psel & penable & ~ready_q & ~mapped;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        // an error answer always carries zero data, write or read
        if (psel & penable & ~ready_q & (~pwrite | ~mapped)) begin
            rdata_d = 32'h0000_0000;
            if (paddr == alu_stage_pkg::CTRL_OFFSET) begin
                rdata_d[alu_stage_pkg::CTRL_PREC_POS +: 2] =
                    ctrl_q.precision;
                rdata_d[alu_stage_pkg::CTRL_SHIFT_POS +:
                        alu_stage_pkg::SHIFT_W] = ctrl_q.shift_amount;
            end else if (paddr == alu_stage_pkg::STATUS_OFFSET) begin
                rdata_d[alu_stage_pkg::STAT_CARRY_POS] = status.carry;
                rdata_d[alu_stage_pkg::STAT_STALL_POS] = status.stall;
                rdata_d[alu_stage_pkg::STAT_SLICE_POS +: 2] = status.slice;
            end
        end
        // write lands only at the edge that completes the transfer
        if (commit & pwrite & (paddr == alu_stage_pkg::CTRL_OFFSET)) begin
            if (pwdata[alu_stage_pkg::CTRL_PREC_POS +: 2] == 2'h3) begin
                ctrl_d.precision = alu_stage_pkg::PREC_16; // undefined code
            end else begin
                ctrl_d.precision = alu_stage_pkg::precision_e'(
                    pwdata[alu_stage_pkg::CTRL_PREC_POS +: 2]);
            end
            ctrl_d.shift_amount = pwdata[alu_stage_pkg::CTRL_SHIFT_POS +:
                                         alu_stage_pkg::SHIFT_W];
        end
    end

    // register stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q.precision <= alu_stage_pkg::CTRL_PREC_RESET;
            ctrl_q.shift_amount <= alu_stage_pkg::CTRL_SHIFT_RESET;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q <= err_d;
        end
    end
endmodule

// file: hw/alu_shifter_input_stage.sv
// input capture stage of a 16-bit alu with a barrel shifter
// assumes operand and select pins synchronous to sys_clk
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module alu_shifter_input_stage (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb register port
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // operand ports
    input wire logic [15:0] first_operand_port,
    input wire logic [15:0] second_operand_port,
    input wire logic first_port_load_enable_n,
    input wire logic second_port_load_enable_n,
    // source selects and scratchpad control
    input wire logic [1:0] alu_first_source_select,
    input wire logic alu_second_source_select,
    input wire logic shifter_source_select,
    input wire logic [1:0] scratch_index,
    input wire logic scratch_load,
    input wire logic issue,
    // cascade carries
    input wire logic carry_input,
    output logic carry_output,
    // shifter result
    output logic [15:0] shifter_result,
    // alu result stream
    output logic result_valid,
    input wire logic result_ready,
    output logic [15:0] result_data,
    output logic result_last
);
    localparam int W = alu_stage_pkg::WORD_W;

    // first source codes of the alu a-side mux
    localparam logic [1:0] ASRC_PORT = 2'h0;
    localparam logic [1:0] ASRC_SCRATCH = 2'h1;
    localparam logic [1:0] ASRC_ALU = 2'h2;
    localparam logic [1:0] ASRC_SHIFT = 2'h3;

    alu_stage_pkg::ctrl_s ctrl; // software control word
    alu_stage_pkg::status_s status; // state shown to software
    alu_stage_pkg::result_s push_word; // word offered to the fifo
    alu_stage_pkg::result_s head_word; // word at the fifo head
    logic fifo_ready; // fifo can take a word
    logic stall; // result pending but fifo full

    // operand input registers (no reset)
    logic [W-1:0] a_reg_q, a_reg_d;
    logic [W-1:0] b_reg_q, b_reg_d;
    // scratchpad (no reset)
    logic [W-1:0] scratch_q [alu_stage_pkg::SCRATCH_N];
    // alu and shifter feedback registers (no reset)
    logic [W-1:0] alu_res_q, alu_res_d;
    logic [W-1:0] shift_res_q, shift_res_d;

    // latched controls, defined after reset
    logic [1:0] a_sel_q, a_sel_d;
    logic b_sel_q, b_sel_d;
    logic s_sel_q, s_sel_d;
    logic [1:0] sp_idx_q, sp_idx_d;
    logic sp_load_q, sp_load_d;
    logic issue_q, issue_d;
    logic cin_pin_q, cin_pin_d;
    // carry kept from the last alu cycle
    logic carry_q, carry_d;
    // slice position inside a multiprecision field
    logic [1:0] slice_q, slice_d;
    // word produced by the alu in the cycle now ending
    logic push_q, push_d;
    logic last_q, last_d;

    // combinational datapath
    logic [W-1:0] a_mux; // alu first operand
    logic [W-1:0] b_mux; // alu second operand
    logic [W-1:0] s_mux; // shifter input
    logic [W-1:0] scratch_rd; // scratchpad word selected by index
    logic alu_cin; // carry into the lsb of the alu
    logic [W:0] alu_sum; // alu result with carry out
    logic [2*W-1:0] s_dbl; // doubled word for rotation
    logic [W-1:0] s_rot; // rotated shifter word
    logic is_last; // current slice closes the field

    // register file and status port
    stage_regs regs (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .ctrl(ctrl),
        .status(status)
    );

    // status bits come from registers only
    always_comb begin
        status.carry = carry_q;
        status.stall = stall;
        status.slice = slice_q;
    end

    // a word waiting for a full fifo freezes the datapath registers (apb still works), so
    // nothing downstream is lost; the pins are ignored meanwhile
    assign stall = push_q & ~fifo_ready;

    // sources are picked by the latched selects, so a select taken
    // at one edge steers the cycle that this edge starts
    always_comb begin
        scratch_rd = scratch_q[sp_idx_q];
        case (a_sel_q)
            ASRC_PORT: a_mux = a_reg_q;
            ASRC_SCRATCH: a_mux = scratch_rd;
            ASRC_ALU: a_mux = alu_res_q;
            ASRC_SHIFT: a_mux = shift_res_q;
            default: a_mux = a_reg_q;
        endcase
        b_mux = b_sel_q ? scratch_rd : b_reg_q;
        s_mux = s_sel_q ? alu_res_q : b_reg_q;
    end

    // alu: the first slice of a field takes the cascade pin, later
    // slices take the carry kept from the alu cycle before
    always_comb begin
        is_last = (slice_q == alu_stage_pkg::last_slice(ctrl.precision));
        alu_cin = (slice_q == 2'h0) ? cin_pin_q : carry_q;
        alu_sum = {1'b0, a_mux} + {1'b0, b_mux} + {{W{1'b0}}, alu_cin};
    end

    // barrel shifter: left rotate by the programmed amount
    always_comb begin
        s_dbl = {s_mux, s_mux} << ctrl.shift_amount;
        s_rot = s_dbl[2*W-1:W];
    end

    // next values of the latched controls and carry
    always_comb begin
        a_sel_d = a_sel_q;
        b_sel_d = b_sel_q;
        s_sel_d = s_sel_q;
        sp_idx_d = sp_idx_q;
        sp_load_d = sp_load_q;
        issue_d = issue_q;
        cin_pin_d = cin_pin_q;
        carry_d = carry_q;
        slice_d = slice_q;
        push_d = push_q;
        last_d = last_q;
        if (!stall) begin
            // selects are latched every edge and act one cycle on
            a_sel_d = alu_first_source_select;
            b_sel_d = alu_second_source_select;
            s_sel_d = shifter_source_select;
            sp_idx_d = scratch_index;
            sp_load_d = scratch_load;
            issue_d = issue;
            cin_pin_d = carry_input;
            // alu carry stored at the end of every cycle
            carry_d = alu_sum[W];
            push_d = issue_q;
            last_d = is_last;
            if (issue_q) begin
                // one slice per issued cycle, wrapping per field
                slice_d = is_last ? 2'h0 : 2'(slice_q + 2'h1);
            end
        end
    end

    // control registers, all on the single rising edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_sel_q <= ASRC_PORT;
            b_sel_q <= 1'b0;
            s_sel_q <= 1'b0;
            sp_idx_q <= 2'h0;
            sp_load_q <= 1'b0;
            issue_q <= 1'b0;
            cin_pin_q <= 1'b0;
            carry_q <= 1'b0;
            slice_q <= 2'h0;
            push_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            a_sel_q <= a_sel_d;
            b_sel_q <= b_sel_d;
            s_sel_q <= s_sel_d;
            sp_idx_q <= sp_idx_d;
            sp_load_q <= sp_load_d;
            issue_q <= issue_d;
            cin_pin_q <= cin_pin_d;
            carry_q <= carry_d;
            slice_q <= slice_d;
            push_q <= push_d;
            last_q <= last_d;
        end
    end

    // next values of the data registers
    always_comb begin
        a_reg_d = a_reg_q;
        b_reg_d = b_reg_q;
        alu_res_d = alu_res_q;
        shift_res_d = shift_res_q;
        if (!stall) begin
            // the active-low enables gate each port register
            if (!first_port_load_enable_n) begin
                a_reg_d = first_operand_port;
            end
            if (!second_port_load_enable_n) begin
                b_reg_d = second_operand_port;
            end
            alu_res_d = alu_sum[W-1:0];
            shift_res_d = s_rot;
        end
    end

    // data registers hold whatever they power up with until loaded;
    // leaving out the reset saves area on the wide paths
    always_ff @(posedge sys_clk) begin
        a_reg_q <= a_reg_d;
        b_reg_q <= b_reg_d;
        alu_res_q <= alu_res_d;
        shift_res_q <= shift_res_d;
    end

    // scratchpad: the latched index picks the word the alu result
    // is written into at the end of the cycle
    genvar gi;
    generate
        for (gi = 0; gi < alu_stage_pkg::SCRATCH_N; gi++) begin : g_sp
            logic [W-1:0] sp_d; // next value of this word
            always_comb begin
                sp_d = scratch_q[gi];
                if (!stall && sp_load_q && (sp_idx_q == 2'(gi))) begin
                    sp_d = alu_sum[W-1:0];
                end
            end
            always_ff @(posedge sys_clk) begin
                scratch_q[gi] <= sp_d;
            end
        end
    endgenerate

    // fifo input word: result registers of the cycle just ended
    always_comb begin
        push_word.last = last_q;
        push_word.carry = carry_q;
        push_word.data = alu_res_q;
    end

    // result buffer; its fullness stalls the stage
    result_fifo #(
        .WIDTH($bits(alu_stage_pkg::result_s)),
        .DEPTH(alu_stage_pkg::FIFO_DEPTH)
    ) fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(push_q),
        .in_ready(fifo_ready),
        .in_data(push_word),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(head_word)
    );

    // stream fields unpacked from the registered head word
    assign result_data = head_word.data;
    assign result_last = head_word.last;
    // cascade output straight from the kept carry
    assign carry_output = carry_q;
    assign shifter_result = shift_res_q;
endmodule

// file: sim/alu_stage_monitor.sv
// port checker for the alu input stage: apb timing and result stream
// assumes it is bound onto the stage top and sees only its ports
`timescale 1ns/10ps
module alu_stage_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // apb side
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and stream
    input wire logic issue,
    input wire logic carry_output,
    input wire logic result_valid,
    input wire logic result_ready,
    input wire logic [15:0] result_data,
    input wire logic result_last
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // access phase still waiting for its answer
    wire acc = psel && penable && !pready;
    // neither of the two mapped words
    wire unmapped = paddr != alu_stage_pkg::CTRL_OFFSET
        && paddr != alu_stage_pkg::STATUS_OFFSET;
    a_apb_one_wait: assert property (acc |=> pready)
        else $error("apb answer late");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_from_access: assert property (pready |->
        $past(psel) && $past(penable))
        else $error("pready without access");
    a_err_decode: assert property (acc |=> pslverr == $past(unmapped))
        else $error("pslverr wrong for address");
    a_err_zero_data: assert property (pslverr |->
        pready && prdata == 32'h0)
        else $error("error answer carries data");
    a_stream_holds: assert property (result_valid && !result_ready
        |=> result_valid && $stable({result_last, result_data}))
        else $error("refused word changed");
    a_first_word_delay: assert property ($rose(result_valid)
        |-> $past(issue, 4))
        else $error("word appeared too early");
    a_reset_quiet: assert property ($rose(rst_n) |->
        !pready && !result_valid && !carry_output)
        else $error("outputs busy after reset");
    // main scenarios reached
    c_err: cover property (pready && pslverr);
    c_refused: cover property (result_valid && !result_ready);
    c_last: cover property (result_valid && result_ready && result_last);
endmodule

bind alu_shifter_input_stage alu_stage_monitor i_alu_stage_monitor (
    .sys_clk, .rst_n, .paddr, .psel, .penable, .prdata, .pready,
    .pslverr, .issue, .carry_output, .result_valid, .result_ready,
    .result_data, .result_last);

// file: sim/result_sink.sv
// sequencer-side model that paces the result stream
// assumes the bench picks hold or slow pacing between edges
`timescale 1ns/10ps
module result_sink (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // pacing chosen by the bench
    input wire logic hold_all,
    input wire logic slow,
    // stream handshake
    output logic result_ready
);
    int seed = 28; // fixed so stalls repeat run to run
    // one slice word per accepted cycle; slow mode refuses about one in four
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_ready <= 1'b0;
        end else begin
            result_ready <= !hold_all && !(slow && $random(seed) % 4 == 0);
        end
    end
endmodule

// file: sim/tb.sv
// self-checking bench for the alu input stage
// assumes a 100 MHz clock and the stage with its result sink model
`timescale 1ns/10ps
module tb;
    // clock, reset, apb
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er;
    // pins driven by the bench
    logic [15:0] a_pin = 16'h0, b_pin = 16'h0;
    logic a_en_n = 1'b0, b_en_n = 1'b0, sel_b = 1'b0, sel_s = 1'b0;
    logic [1:0] sel_a = 2'h0, idx = 2'h0;
    logic ld = 1'b0, iss = 1'b0, cin_pin = 1'b0;
    logic hold_all = 1'b0, slow = 1'b0;
    // outputs
    logic carry_output, result_valid, result_ready, result_last;
    logic [15:0] shifter_result, result_data;
    // reference model state
    logic [15:0] a_r, b_r, alu_r, sh_r, cval;
    logic [15:0] sp [4];
    logic cy_r, sb_l, ss_l, sl_l, is_l, ci_l;
    logic [1:0] sa_l, idx_l, slc = 2'h0, lst = 2'h0;
    logic [3:0] sh_amt = 4'h0;
    logic track = 1'b1, chk_on = 1'b0;
    logic [16:0] q [$];
    int n_errors = 0, tests_run = 0, seed = 28, n_got = 0;

    alu_shifter_input_stage i_alu_shifter_input_stage (.sys_clk, .rst_n,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .first_operand_port(a_pin), .second_operand_port(b_pin),
        .first_port_load_enable_n(a_en_n), .second_port_load_enable_n(b_en_n),
        .alu_first_source_select(sel_a), .alu_second_source_select(sel_b),
        .shifter_source_select(sel_s), .scratch_index(idx),
        .scratch_load(ld), .issue(iss), .carry_input(cin_pin),
        .carry_output, .shifter_result, .result_valid, .result_ready,
        .result_data, .result_last);
    result_sink i_result_sink (.sys_clk, .rst_n, .hold_all, .slow,
        .result_ready);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one apb transfer; waits for pready under a bound
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            chk(1'b0, "apb timeout");
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // reference model: compare last step, then step one cycle
    always @(posedge sys_clk) begin
        logic [15:0] va, vb, shs;
        logic [16:0] s, w;
        if (chk_on) begin
            chk(carry_output === cy_r, "kept carry");
            chk(shifter_result === sh_r, "shifter word");
        end
        if (result_valid === 1'b1 && result_ready === 1'b1) begin
            if (!track) begin
                n_got++;
                chk({result_last, result_data} === {1'b1, cval}, "fill");
            end else if (q.size() == 0) begin
                chk(1'b0, "extra word");
            end else begin
                w = q.pop_front();
                chk({result_last, result_data} === w, "word");
            end
        end
        if (track && rst_n === 1'b1) begin
            va = sa_l == 2'h0 ? a_r : sa_l == 2'h1 ? sp[idx_l]
                : sa_l == 2'h2 ? alu_r : sh_r;
            vb = sb_l ? sp[idx_l] : b_r;
            s = va + vb + (slc == 2'h0 ? ci_l : cy_r);
            shs = ss_l ? alu_r : b_r;
            sh_r = (shs << sh_amt) | (shs >> (16 - sh_amt));
            if (is_l) begin
                q.push_back({slc == lst, s[15:0]});
                slc = slc == lst ? 2'h0 : slc + 2'h1;
            end
            if (sl_l)
                sp[idx_l] = s[15:0];
            alu_r = s[15:0];
            cy_r = s[16];
            if (!a_en_n)
                a_r = a_pin;
            if (!b_en_n)
                b_r = b_pin;
            {sa_l, idx_l, sb_l, ss_l, sl_l, is_l, ci_l} =
                {sel_a, idx, sel_b, sel_s, ld, iss, cin_pin};
        end
    end

    // set precision and shift, then random pins for n cycles
    task run(input logic [1:0] p, input int n);
        logic [3:0] sh;
        logic [1:0] pe;
        sh = 4'($random(seed));
        pe = p == 2'h3 ? 2'h0 : p;
        @(negedge sys_clk);
        chk_on = 1'b0;
        apb(1'b1, alu_stage_pkg::CTRL_OFFSET, {24'h0, sh, 2'h0, p});
        // write lands at this edge; the model follows from the next one
        sh_amt <= sh;
        lst <= pe == 2'h1 ? 2'h1 : pe == 2'h2 ? 2'h3 : 2'h0;
        apb(1'b0, alu_stage_pkg::CTRL_OFFSET, 32'h0);
        chk(rd === {24'h0, sh, 2'h0, pe}, "control word");
        @(negedge sys_clk);
        slow = pe == 2'h0;
        chk_on = 1'b1;
        repeat (n) begin
            @(posedge sys_clk);
            a_pin <= 16'($random(seed));
            b_pin <= 16'($random(seed));
            {a_en_n, b_en_n, sel_b, sel_s, ld, cin_pin} <= 6'($random(seed));
            sel_a <= 2'($random(seed));
            idx <= 2'($random(seed));
            iss <= pe != 2'h0 || $random(seed) % 4 == 0;
        end
        @(posedge sys_clk);
        iss <= 1'b0;
        repeat (12) @(negedge sys_clk);
        chk(q.size() == 0, "words missing");
        $display("test precision %0d done", p);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        chk(1'b0, "run too long");
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk(!pready && !result_valid && carry_output === 1'b0, "reset");
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            a_pin <= 16'($random(seed));
            idx <= 2'(i);
            ld <= 1'b1;
        end
        apb(1'b0, alu_stage_pkg::CTRL_OFFSET, 32'h0);
        chk(rd === 32'h0 && er === 1'b0, "control reset");
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk(er === 1'b1, "unmapped write");
        apb(1'b0, 8'h08, 32'h0);
        chk(er === 1'b1 && rd === 32'h0, "unmapped read");
        $display("test registers done");
        for (int p = 0; p < 4; p++)
            run(2'(p), 64);
        // fill the fifo with the sink holding off, then drain
        @(negedge sys_clk);
        track = 1'b0;
        chk_on = 1'b0;
        slow = 1'b0;
        hold_all = 1'b1;
        cval = 16'($random(seed));
        @(posedge sys_clk);
        {a_pin, b_pin, sel_a, sel_b, a_en_n, b_en_n} <= {cval, 21'h0};
        {cin_pin, ld, iss} <= 3'h1;
        repeat (14) @(posedge sys_clk);
        iss <= 1'b0;
        apb(1'b0, alu_stage_pkg::STATUS_OFFSET, 32'h0);
        chk(rd[alu_stage_pkg::STAT_STALL_POS] === 1'b1, "stall flag");
        @(negedge sys_clk);
        hold_all = 1'b0;
        repeat (40) @(negedge sys_clk);
        chk(n_got >= 8 && n_got <= 14 && !result_valid, "drain");
        $display("test fifo done");
        tally_and_finish();
    end
endmodule
